// ==== hw/ram_consts.svh ====
// Constants of the DS3 receive alarm monitor: offsets, fields, resets, counts.
// Assumes inclusion by bare name from the hw/ folder.
`ifndef RAM_CONSTS_SVH
`define RAM_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets on the microprocessor port
`define RAM_OFF_INIT      8'h1f
`define RAM_OFF_AIS_SEL   8'h21
`define RAM_OFF_STATUS    8'h24

////////////////////////////////////////////////////////////////////////////////
// Status register fields
`define RAM_ST_XONE_BIT   7
`define RAM_ST_CZERO_BIT  6
`define RAM_ST_TEST_HI    5
`define RAM_ST_TEST_LO    2
`define RAM_ST_UNUSED_BIT 1
`define RAM_ST_SEF_BIT    0

// Receive AIS selection field inside the selection register
`define RAM_SEL_HI        4
`define RAM_SEL_LO        2
`define RAM_SEL_ANSI      3'h1

////////////////////////////////////////////////////////////////////////////////
// Reset values and initialization codes
`define RAM_RST_INIT      8'h00
`define RAM_RST_AIS_SEL   8'h00
`define RAM_RST_TEST      4'h0
`define RAM_INIT_RESET    8'hf0
`define RAM_INIT_PRESET   8'h00

////////////////////////////////////////////////////////////////////////////////
// Filter counts
`define RAM_XONE_MOD      16
`define RAM_XZERO_MOD     4
`define RAM_C_FRAMES      7
`define RAM_C_MAX_ONES    30
`define RAM_SEF_WIN       16
`define RAM_SEF_ERRS      3

`endif

// ==== hw/ram_pkg.sv ====
// Types shared by the DS3 receive alarm monitor.
// Assumes ram_consts.svh supplies the numbers; this package holds types only.
package ram_pkg;

	// Overhead strobes from the receive framer, on the link clock
	typedef struct packed {
		logic mfrm_end;
		logic xbit_vld;
		logic cbit_vld;
		logic fbit_vld;
		logic data;
		logic fbit_exp;
	} ram_rx_ovh_s;

	// Alarm levels produced in the link domain
	typedef struct packed {
		logic x_one;
		logic c_zero;
		logic severe_frame_error_flag;
	} ram_alarm_s;

endpackage : ram_pkg

// ==== hw/ram_sync.sv ====
// Two-flop level synchroniser for a bus of independent levels.
// Assumes each bit is a slow level; multi-bit words are not kept coherent.
`timescale 1ns/1ps

module ram_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	if (W < 1) begin : g_bad_w
		$error("ram_sync: W must be at least 1");
	end

	// First stage feeds the second stage only
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : ram_sync

// ==== hw/ram_top.sv ====
// DS3 receive alarm monitor: X-bit, C-bit and F-bit filters, cleared-on-read status.
// Assumes the microprocessor port is synchronous to mclk and that a framer
// delivers overhead strobes on the recovered line clock lclk.
//
// What this block does
// [RULE1] Mod-16 counter of X-bit pairs both one
// [RULE2] Mod-4 counter of X-bit pairs both zero
// [RULE3] Either counter maturing resets both counters
// [RULE4] Ones counter maturing latches status bit 7
// [RULE5] Bit 7 is X criterion when select 001
// [RULE6] Seven frames with <=30 C-ones set bit 6
// [RULE7] Bit 6 is C criterion when select high bits zero
// [RULE8] Flags stay set until status read clears
// [RULE9] Flag relatches if its condition persists
// [RULE10] Three F errors in sixteen set bit 0
// [RULE11] Bits 5..2 are diagnostic only, bit 1 unused
// [RULE12] Host writes F0 to 1F to reset
// [RULE13] Host then writes 00 to preset, finishing init
// [RULE14] Unused status bit 1 reads zero always
`timescale 1ns/1ps
`include "ram_consts.svh"

module ram_top #(
	parameter int XONE_MOD    = `RAM_XONE_MOD,
	parameter int XZERO_MOD   = `RAM_XZERO_MOD,
	parameter int C_FRAMES    = `RAM_C_FRAMES,
	parameter int C_MAX_ONES  = `RAM_C_MAX_ONES,
	parameter int SEF_WIN     = `RAM_SEF_WIN,
	parameter int SEF_ERRS    = `RAM_SEF_ERRS
) (
	input  wire logic                mclk,
	input  wire logic                arst_n,
	input  wire logic                lclk,
	input  wire logic [7:0]          up_addr,
	input  wire logic [7:0]          up_wdata,
	input  wire logic                up_wr,
	input  wire logic                up_rd,
	input  wire ram_pkg::ram_rx_ovh_s rx_ovh,
	output logic      [7:0]          up_rdata_q,
	output logic                     up_rvalid_q,
	output logic                     ais_detected_q,
	output logic                     link_hold_q
);

	import ram_pkg::*;

	localparam int ONES_W = $clog2(XONE_MOD);
	localparam int ZERO_W = $clog2(XZERO_MOD);
	localparam int CNT_W  = $clog2(C_MAX_ONES + 2);
	localparam int FRM_W  = $clog2(C_FRAMES + 1);
	localparam int POP_W  = $clog2(SEF_WIN + 1);

	localparam logic [ONES_W-1:0] ONES_TERM = ONES_W'(XONE_MOD - 1);
	localparam logic [ZERO_W-1:0] ZERO_TERM = ZERO_W'(XZERO_MOD - 1);
	localparam logic [CNT_W-1:0]  CNT_MAX   = CNT_W'(C_MAX_ONES);
	localparam logic [CNT_W-1:0]  CNT_SAT   = CNT_W'(C_MAX_ONES + 1);
	localparam logic [FRM_W-1:0]  FRM_TERM  = FRM_W'(C_FRAMES);
	localparam logic [POP_W-1:0]  ERR_TERM  = POP_W'(SEF_ERRS);

	// The F window shifts through a part-select, so it needs two bits at least
	if (XONE_MOD < 2 || XZERO_MOD < 2) begin : g_bad_x
		$error("ram_top: X filter moduli too small");
	end
	if (C_FRAMES < 1 || C_MAX_ONES < 1) begin : g_bad_c
		$error("ram_top: C filter counts too small");
	end
	if (SEF_WIN < 2 || SEF_ERRS < 1 || SEF_ERRS > SEF_WIN) begin : g_bad_f
		$error("ram_top: bad F-bit window");
	end

	// One address comparator shape for every register decode
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
		addr_hit = (a == off);
	endfunction : addr_hit

	// Count of set bits in the F-bit error window
	function automatic logic [POP_W-1:0] pop_count(input logic [SEF_WIN-1:0] v);
		pop_count = '0;
		for (int i = 0; i < SEF_WIN; i++) begin
			pop_count = pop_count + POP_W'(v[i]);
		end
	endfunction : pop_count

	////////////////////////////////////////////////////////////////////////////
	// Microprocessor port decode (mclk)

	logic [7:0] init_q;
	logic [7:0] init_d;
	logic [7:0] ais_sel_q;
	logic [7:0] ais_sel_d;
	logic [3:0] test_q;
	logic [3:0] test_d;

	wire hit_init   = addr_hit(up_addr, `RAM_OFF_INIT);
	wire hit_sel    = addr_hit(up_addr, `RAM_OFF_AIS_SEL);
	wire hit_status = addr_hit(up_addr, `RAM_OFF_STATUS);
	wire wr_init    = up_wr & hit_init;
	wire wr_sel     = up_wr & hit_sel;
	wire wr_status  = up_wr & hit_status;
	wire rd_status  = up_rd & hit_status;

	assign init_d    = wr_init ? up_wdata : init_q;
	assign ais_sel_d = wr_sel ? up_wdata : ais_sel_q;
	assign test_d    = wr_status ? up_wdata[`RAM_ST_TEST_HI:`RAM_ST_TEST_LO] : test_q; // [RULE11]

	// F0 holds the link filters cleared; any other code, normally 00, lets them run
	wire link_hold_d = (init_q == `RAM_INIT_RESET); // [RULE12] [RULE13]

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			init_q      <= `RAM_RST_INIT;
			ais_sel_q   <= `RAM_RST_AIS_SEL;
			test_q      <= `RAM_RST_TEST;
			link_hold_q <= 1'b0;
		end else begin
			init_q      <= init_d;
			ais_sel_q   <= ais_sel_d;
			test_q      <= test_d;
			link_hold_q <= link_hold_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Hold level into the link domain

	logic hold_l;

	ram_sync #(
		.W (1)
	) u_hold_sync (
		.clk    (lclk),
		.arst_n (arst_n),
		.d      (link_hold_q),
		.q      (hold_l)
	);

	////////////////////////////////////////////////////////////////////////////
	// Link domain: overhead capture (lclk)

	ram_rx_ovh_s ovh_q;

	always_ff @(posedge lclk or negedge arst_n) begin
		if (!arst_n) begin
			ovh_q <= '0;
		end else begin
			ovh_q <= rx_ovh;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// X-bit pair filter

	logic              xfirst_q;
	logic              xfirst_d;
	logic              xval_q;
	logic              xval_d;
	logic [ONES_W-1:0] ones_q;
	logic [ONES_W-1:0] ones_d;
	logic [ZERO_W-1:0] zeros_q;
	logic [ZERO_W-1:0] zeros_d;
	logic              x_one_q;
	logic              x_one_d;

	wire pair_done   = ovh_q.xbit_vld & xfirst_q;
	wire pair_ones   = pair_done & xval_q & ovh_q.data;
	wire pair_zeros  = pair_done & ~xval_q & ~ovh_q.data;
	wire ones_mature = pair_ones & (ones_q == ONES_TERM);  // [RULE1]
	wire zero_mature = pair_zeros & (zeros_q == ZERO_TERM); // [RULE2]
	wire x_mature    = ones_mature | zero_mature;

	// Pairing restarts each M-frame so a dropped strobe cannot skew it
	assign xfirst_d = ovh_q.mfrm_end ? 1'b0 : (ovh_q.xbit_vld ? ~xfirst_q : xfirst_q);
	assign xval_d   = (ovh_q.xbit_vld & ~xfirst_q) ? ovh_q.data : xval_q;
	assign ones_d   = x_mature ? '0 : (pair_ones ? ones_q + 1'b1 : ones_q);     // [RULE1] [RULE3]
	assign zeros_d  = x_mature ? '0 : (pair_zeros ? zeros_q + 1'b1 : zeros_q); // [RULE2] [RULE3]
	assign x_one_d  = ones_mature ? 1'b1 : (zero_mature ? 1'b0 : x_one_q);     // [RULE4]

	always_ff @(posedge lclk or negedge arst_n) begin
		if (!arst_n) begin
			xfirst_q <= 1'b0;
			xval_q   <= 1'b0;
			ones_q   <= '0;
			zeros_q  <= '0;
			x_one_q  <= 1'b0;
		end else if (hold_l) begin
			xfirst_q <= 1'b0;
			xval_q   <= 1'b0;
			ones_q   <= '0;
			zeros_q  <= '0;
			x_one_q  <= 1'b0;
		end else begin
			xfirst_q <= xfirst_d;
			xval_q   <= xval_d;
			ones_q   <= ones_d;
			zeros_q  <= zeros_d;
			x_one_q  <= x_one_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// C-bit filter

	logic [CNT_W-1:0] cones_q;
	logic [CNT_W-1:0] cones_d;
	logic [FRM_W-1:0] cfrm_q;
	logic [FRM_W-1:0] cfrm_d;
	logic             c_zero_q;

	// Count saturates one past the limit, enough to mark a failing frame
	wire cbit_one   = ovh_q.cbit_vld & ovh_q.data & (cones_q != CNT_SAT);
	wire frame_good = (cones_q <= CNT_MAX); // [RULE6]

	assign cones_d = ovh_q.mfrm_end ? '0 : (cbit_one ? cones_q + 1'b1 : cones_q);
	assign cfrm_d  = !ovh_q.mfrm_end ? cfrm_q :
	                 !frame_good ? '0 :
	                 (cfrm_q == FRM_TERM) ? cfrm_q : cfrm_q + 1'b1; // [RULE6]

	always_ff @(posedge lclk or negedge arst_n) begin
		if (!arst_n) begin
			cones_q  <= '0;
			cfrm_q   <= '0;
			c_zero_q <= 1'b0;
		end else if (hold_l) begin
			cones_q  <= '0;
			cfrm_q   <= '0;
			c_zero_q <= 1'b0;
		end else begin
			cones_q  <= cones_d;
			cfrm_q   <= cfrm_d;
			c_zero_q <= (cfrm_d == FRM_TERM); // [RULE6]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// F-bit sliding window

	logic [SEF_WIN-1:0] fwin_q;
	logic [SEF_WIN-1:0] fwin_d;
	logic               sef_q;

	wire f_err = ovh_q.data ^ ovh_q.fbit_exp;

	assign fwin_d = ovh_q.fbit_vld ? {fwin_q[SEF_WIN-2:0], f_err} : fwin_q; // [RULE10]

	always_ff @(posedge lclk or negedge arst_n) begin
		if (!arst_n) begin
			fwin_q <= '0;
			sef_q  <= 1'b0;
		end else if (hold_l) begin
			fwin_q <= '0;
			sef_q  <= 1'b0;
		end else begin
			fwin_q <= fwin_d;
			sef_q  <= (pop_count(fwin_d) >= ERR_TERM); // [RULE10]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Alarm levels into mclk; each lasts at least one lclk, far above two mclk

	ram_alarm_s alarm_l;
	ram_alarm_s alarm_m;

	assign alarm_l = '{x_one: x_one_q, c_zero: c_zero_q, severe_frame_error_flag: sef_q};

	ram_sync #(
		.W ($bits(ram_alarm_s))
	) u_alarm_sync (
		.clk    (mclk),
		.arst_n (arst_n),
		.d      (alarm_l),
		.q      (alarm_m)
	);

	////////////////////////////////////////////////////////////////////////////
	// Latched status flags; a set in the clearing cycle wins

	logic [2:0] flag_q;
	logic [2:0] flag_d;
	logic [2:0] cond_m;

	assign cond_m = {alarm_m.x_one, alarm_m.c_zero, alarm_m.severe_frame_error_flag};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_flag
			assign flag_d[gi] = (flag_q[gi] & ~rd_status) | cond_m[gi]; // [RULE8] [RULE9]
		end
	endgenerate

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			flag_q <= '0;
		end else begin
			flag_q <= flag_d;
		end
	end

	wire [7:0] status_word = {flag_q[2], flag_q[1], test_q, 1'b0, flag_q[0]}; // [RULE14] [RULE11]

	////////////////////////////////////////////////////////////////////////////
	// Read data; unmapped addresses read zero

	wire [7:0] rd_mux = hit_status ? status_word :
	                    hit_sel ? ais_sel_q :
	                    hit_init ? init_q : 8'h00;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			up_rdata_q  <= 8'h00;
			up_rvalid_q <= 1'b0;
		end else begin
			up_rdata_q  <= up_rd ? rd_mux : up_rdata_q;
			up_rvalid_q <= up_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AIS detection from the latched flags and the receive selection field

	wire [2:0] rx_sel  = ais_sel_q[`RAM_SEL_HI:`RAM_SEL_LO];
	wire       c_mode  = (rx_sel[2:1] == 2'b00);
	wire       x_crit  = (rx_sel == `RAM_SEL_ANSI) ? flag_q[2] : 1'b1; // [RULE5]
	wire       c_crit  = c_mode ? flag_q[1] : 1'b0;                    // [RULE7]
	// Other selections are left undetected here; they belong to other monitors
	wire       ais_d   = c_mode & x_crit & c_crit;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ais_detected_q <= 1'b0;
		end else begin
			ais_detected_q <= ais_d;
		end
	end

endmodule : ram_top

// ==== tb/ram_link_model.sv ====
// Framer model: overhead strobes for the alarm monitor on the line clock.
// Assumes the bench runs lclk freely and calls the tasks below by hierarchy.
`timescale 1ns/1ps
module ram_link_model (
	input  wire logic           lclk,
	output ram_pkg::ram_rx_ovh_s ovh
);
	import ram_pkg::*;
	initial ovh = '0;
	////////////////////////////////////////////////////////////
	// One strobe per lclk at most; fbit_exp kept 0 so data 1 is an F error
	task automatic put(input logic [3:0] k, input logic d);
		@(posedge lclk);
		#1 ovh = {k, d, 1'b0};
	endtask : put
	// Between strobes the data line flips so a stale value never looks valid
	task automatic idle();
		put(4'h0, ~ovh.data);
	endtask : idle
	task automatic xp(input logic d, input int n);
		repeat (2 * n) put(4'h4, d);
		idle();
	endtask : xp
	task automatic fr(input int ones, input int n);
		repeat (n) begin
			repeat (ones) put(4'h2, 1'b1);
			put(4'h8, 1'b0);
		end
		idle();
	endtask : fr
	task automatic fb(input logic e, input int n);
		repeat (n) put(4'h1, e);
		idle();
	endtask : fb
endmodule : ram_link_model

// ==== tb/ram_top_assertions.sv ====
// Checker for the monitor's register port and init hold.
// Assumes it is bound onto ram_top and sees its ports only.
`timescale 1ns/1ps
module ram_top_chk (
	input wire logic       mclk,
	input wire logic       arst_n,
	input wire logic [7:0] up_addr,
	input wire logic [7:0] up_wdata,
	input wire logic       up_wr,
	input wire logic       up_rd,
	input wire logic [7:0] up_rdata_q,
	input wire logic       up_rvalid_q,
	input wire logic       link_hold_q
);
	wire logic init_wr = up_wr && up_addr == 8'h1f;
	wire logic mapped  = up_addr == 8'h1f || up_addr == 8'h21 || up_addr == 8'h24;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////
	rvalid_pulse_a: assert property (up_rd |=> up_rvalid_q)
		else $error("rvalid missing after read");
	rvalid_only_a: assert property (!up_rd |=> !up_rvalid_q)
		else $error("rvalid without read");
	rdata_hold_a: assert property (!up_rd |=> $stable(up_rdata_q))
		else $error("read data moved without read");
	unused_bit_a: assert property (up_rd && up_addr == 8'h24 |=> !up_rdata_q[1])
		else $error("status bit 1 not zero");
	unmapped_rd_a: assert property (up_rd && !mapped |=> up_rdata_q == 8'h00)
		else $error("unmapped read not zero");
	hold_set_a: assert property (init_wr && up_wdata == 8'hf0 |-> ##2 link_hold_q)
		else $error("hold missing after reset code");
	hold_clr_a: assert property (init_wr && up_wdata == 8'h00 |-> ##2 !link_hold_q)
		else $error("hold stuck after preset code");
	hold_keep_a: assert property (!up_wr && !$past(up_wr) |=> $stable(link_hold_q))
		else $error("hold moved without write");
	cover property (up_rvalid_q && up_rdata_q[7]);
	cover property (up_rvalid_q && up_rdata_q[0]);
	cover property ($rose(link_hold_q));
endmodule : ram_top_chk

bind ram_top ram_top_chk u_chk (
	.mclk(mclk), .arst_n(arst_n), .up_addr(up_addr), .up_wdata(up_wdata),
	.up_wr(up_wr), .up_rd(up_rd), .up_rdata_q(up_rdata_q),
	.up_rvalid_q(up_rvalid_q), .link_hold_q(link_hold_q)
);

// ==== tb/tb_top.sv ====
// Self-checking bench for the receive alarm monitor.
// Assumes ram_top with default counts and the framer model beside it.
`timescale 1ns/1ps
module tb_top;
	import ram_pkg::*;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} ram_row_s;
	logic        mclk = 0, lclk = 0, arst_n = 0, up_wr = 0, up_rd = 0;
	logic [7:0]  up_addr = 0, up_wdata = 0, up_rdata_q;
	logic        up_rvalid_q, ais_detected_q, link_hold_q;
	ram_rx_ovh_s rx_ovh;
	int          n_errors = 0, cmp_count = 0;
	// Status test bits are cleared again so later status reads see flags only
	ram_row_s    rows [6] = '{'{8'h21, 8'h04, 8'h04}, '{8'h24, 8'hff, 8'h3c},
		'{8'h24, 8'h00, 8'h00}, '{8'h30, 8'h5a, 8'h00},
		'{8'h1f, 8'hf0, 8'hf0}, '{8'h1f, 8'h00, 8'h00}};
	always #2.5 mclk = ~mclk;
	initial begin
		#1.3;
		forever #16 lclk = ~lclk;
	end
	ram_top DUT (.mclk(mclk), .arst_n(arst_n), .lclk(lclk), .up_addr(up_addr),
		.up_wdata(up_wdata), .up_wr(up_wr), .up_rd(up_rd), .rx_ovh(rx_ovh),
		.up_rdata_q(up_rdata_q), .up_rvalid_q(up_rvalid_q),
		.ais_detected_q(ais_detected_q), .link_hold_q(link_hold_q));
	ram_link_model u_link (.lclk(lclk), .ovh(rx_ovh));
	////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [7:0] v, input logic [7:0] e);
		cmp_count++;
		if (v !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", s, e, v);
		end
	endtask : chk
	task automatic ck1(input string s, input logic v, input logic e);
		chk(s, {7'h0, v}, {7'h0, e});
	endtask : ck1
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 {up_addr, up_wdata, up_wr} = {a, d, 1'b1};
		@(posedge mclk);
		#1 up_wr = 0;
		repeat (2) @(posedge mclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk);
		#1 {up_addr, up_rd} = {a, 1'b1};
		@(posedge mclk);
		#1 up_rd = 0;
		chk($sformatf("reg %h", a), up_rdata_q, e);
		ck1("rvalid", up_rvalid_q, 1'b1);
	endtask : rd
	// Flags cross two domains, so wait out both synchronising paths
	task automatic settle();
		repeat (4) @(posedge lclk);
		repeat (6) @(posedge mclk);
	endtask : settle
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////
	initial begin
		#100us;
		n_errors++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge lclk);
		ck1("hold in reset", link_hold_q, 1'b0);
		#1 arst_n = 1;
		repeat (3) @(posedge mclk);
		rd(8'h24, 8'h00);
		rd(8'h1f, 8'h00);
		rd(8'h21, 8'h00);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].e);
		end
		$display("register table done");
		// The preset write must reach the link domain before X bits arrive
		settle();
		u_link.xp(1, 15); settle(); rd(8'h24, 8'h00);
		u_link.xp(1, 1); settle(); rd(8'h24, 8'h80);
		rd(8'h24, 8'h80);
		u_link.fr(30, 6); settle(); rd(8'h24, 8'h80);
		u_link.fr(30, 1); settle(); rd(8'h24, 8'hc0);
		ck1("ais both", ais_detected_q, 1'b1);
		u_link.xp(1, 8); u_link.xp(0, 3); settle(); rd(8'h24, 8'hc0);
		rd(8'h24, 8'hc0);
		u_link.xp(0, 1); settle(); rd(8'h24, 8'hc0);
		rd(8'h24, 8'h40);
		@(posedge mclk);
		#1 ck1("ais no x", ais_detected_q, 1'b0);
		wr(8'h21, 8'h00); ck1("ais c only", ais_detected_q, 1'b1);
		wr(8'h21, 8'h10); ck1("ais high sel", ais_detected_q, 1'b0);
		u_link.xp(1, 15); settle(); rd(8'h24, 8'h40);
		$display("x and c filter test done");
		u_link.fb(1, 2); u_link.fb(0, 13); settle(); rd(8'h24, 8'h40);
		u_link.fb(1, 1); settle(); rd(8'h24, 8'h41);
		rd(8'h24, 8'h41);
		$display("f filter test done");
		wr(8'h1f, 8'hf0); ck1("hold on", link_hold_q, 1'b1);
		settle(); rd(8'h24, 8'h41); rd(8'h24, 8'h00);
		u_link.xp(1, 16); settle(); rd(8'h24, 8'h00);
		wr(8'h1f, 8'h00); ck1("hold off", link_hold_q, 1'b0);
		settle();
		u_link.xp(1, 16); settle(); rd(8'h24, 8'h80);
		// A frame with 31 C ones breaks the run of good frames
		u_link.fr(30, 6);
		u_link.fr(31, 1);
		u_link.fr(30, 6);
		settle();
		rd(8'h24, 8'h80);
		$display("init test done");
		report_and_stop();
	end
endmodule : tb_top
